// ### emw_writer.sv
// Extension module register writer: sequencer, handshake flags and APB front end.
//
// What this block does
// RULE1 - Done rises after all values written.
// RULE2 - Done holds until start falls.
// RULE3 - Start edge raises busy and active together.
// RULE4 - Normal run: done next period, busy drops.
// RULE5 - Error on write fail or illegal inputs.
// RULE6 - Fault code appears with the error flag.
// RULE7 - Start falling clears error and fault code.
// RULE8 - Right positions zero to seven accepted.
// RULE9 - Left positions are one hundred plus slot.
// RULE10 - Out of range position aborts with error.
// RULE11 - Consecutive source elements to consecutive registers.
// RULE12 - Right numbering counts special modules only.
// RULE13 - Eight modules per side at most.
// RULE14 - Requester gives count one to sixty-four.
// RULE15 - Requester gives first target register index.
// RULE16 - Parameters latched on start edge.
// RULE17 - Start edges ignored while busy.
`timescale 1ns/1ps
module emw_writer
  import emw_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Extension module write port
  output logic             mod_wr_valid,
  output emw_wr_t          mod_wr,
  input  wire logic        mod_wr_ack,
  input  wire logic        mod_wr_fail,
  // Handshake flags
  output logic             done_r,
  output logic             busy_r,
  output logic             active_r,
  output logic             error_r,
  output logic      [15:0] fault_code_r,
  output logic             irq
);

  typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_HOLD} emw_state_t;

  emw_state_t  state_r;
  logic        start_r;
  emw_req_t    req_in;
  emw_req_t    req_r;
  logic        start_d_r;
  logic        start_rise;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic        fail_s1_r;
  logic        fail_s2_r;
  logic [6:0]  left_r;
  logic [5:0]  idx_r;
  logic [15:0] tgt_r;
  logic [15:0] src_data;
  logic        pos_ok;
  logic        pos_left;
  logic [2:0]  pos_slot;
  logic        ev_done;
  logic        ev_err;
  logic [6:0]  acked_r;

  emw_apb_regs #(.DEPTH(DEPTH)) u_regs (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .start_r  (start_r),
    .req_r    (req_in),
    .src_idx  (idx_r),
    .src_data (src_data),
    .status   ({error_r, done_r, active_r, busy_r}),
    .fault    (fault_code_r),
    .ev_done  (ev_done),
    .ev_err   (ev_err),
    .irq      (irq)
  );

  // Right-side numbering of special modules only is the caller's encoding; slots map 1:1.
  emw_pos_decode u_pos (
    .position  (req_in.position), // RULE12
    .valid     (pos_ok),
    .left_side (pos_left),
    .slot      (pos_slot)
  );

  // Acknowledge comes from the module bus, outside this clock.
  // Fail travels beside it through the same two stages, so both stay aligned.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      fail_s1_r <= 1'b0;
      fail_s2_r <= 1'b0;
    end else begin
      ack_s1_r  <= mod_wr_ack;
      ack_s2_r  <= ack_s1_r;
      fail_s1_r <= mod_wr_fail;
      fail_s2_r <= fail_s1_r;
    end
  end

  // Counts the writes of the current run answered without fail.
  // The done check compares it with the latched count, so a lost write shows up.
  always_ff @(posedge ref_clk) begin
    if (rst || state_r == ST_IDLE) begin
      acked_r <= 7'h00;
    end else if (state_r == ST_WAIT && ack_s2_r && !fail_s2_r) begin
      acked_r <= acked_r + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= start_r;
    end
  end

  // Only a fresh edge in idle starts a run; held start after done does not restart.
  assign start_rise = start_r && !start_d_r && state_r == ST_IDLE; // RULE17

  // Events for the interrupt status; each is a one-cycle pulse.
  assign ev_done = (state_r == ST_WAIT) && ack_s2_r && !fail_s2_r && left_r == 7'h01;
  assign ev_err  = (start_rise && (!pos_ok || req_in.count < COUNT_MIN
                                   || req_in.count > COUNT_MAX
                                   || 7'(req_in.source_ref) + req_in.count > 7'(DEPTH)))
                   || (state_r == ST_WAIT && ack_s2_r && fail_s2_r);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      req_r        <= '0;
      left_r       <= 7'h00;
      idx_r        <= 6'h00;
      tgt_r        <= 16'h0000;
      done_r       <= 1'b0;
      busy_r       <= 1'b0;
      active_r     <= 1'b0;
      error_r      <= 1'b0;
      fault_code_r <= FAULT_NONE;
      mod_wr_valid <= 1'b0;
      mod_wr       <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_rise) begin
            req_r <= req_in; // RULE16
            if (!pos_ok) begin
              error_r      <= 1'b1; // RULE10
              fault_code_r <= FAULT_POSITION; // RULE6
              state_r      <= ST_HOLD;
            end else if (req_in.count < COUNT_MIN || req_in.count > COUNT_MAX) begin
              error_r      <= 1'b1; // RULE5
              fault_code_r <= FAULT_COUNT;
              state_r      <= ST_HOLD;
            end else if (7'(req_in.source_ref) + req_in.count > 7'(DEPTH)) begin
              error_r      <= 1'b1;
              fault_code_r <= FAULT_SOURCE;
              state_r      <= ST_HOLD;
            end else begin
              busy_r   <= 1'b1; // RULE3
              active_r <= 1'b1;
              left_r   <= req_in.count;
              idx_r    <= req_in.source_ref;
              tgt_r    <= req_in.first_target; // RULE15
              mod_wr.left_side <= pos_left; // RULE13
              mod_wr.slot      <= pos_slot;
              state_r  <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          // The synchronised acknowledge of the previous write lingers for three cycles after it is taken.
          // Issuing before it has fallen would pair the new write with the old answer.
          if (!ack_s2_r) begin
            mod_wr_valid  <= 1'b1;
            mod_wr.target <= tgt_r;
            mod_wr.data   <= src_data; // RULE11
            state_r       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ack_s2_r) begin
            mod_wr_valid <= 1'b0;
            if (fail_s2_r) begin
              busy_r       <= 1'b0; // RULE5
              active_r     <= 1'b0;
              error_r      <= 1'b1;
              fault_code_r <= FAULT_WRITE; // RULE6
              state_r      <= ST_HOLD;
            end else if (left_r == 7'h01) begin
              busy_r   <= 1'b0; // RULE4
              active_r <= 1'b0;
              done_r   <= 1'b1; // RULE1
              state_r  <= ST_HOLD;
            end else begin
              left_r  <= left_r - 7'h01;
              idx_r   <= idx_r + 6'h01; // RULE11
              tgt_r   <= tgt_r + 16'h0001;
              state_r <= ST_ISSUE;
            end
          end
        end
        ST_HOLD: begin
          // Flags stay up until start falls, so a slow program never misses the outcome.
          if (!start_r) begin
            done_r       <= 1'b0; // RULE2
            error_r      <= 1'b0; // RULE7
            fault_code_r <= FAULT_NONE;
            state_r      <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // A write counts as answered when the synchronised acknowledge is seen while waiting.
  // Building the checks from this one step keeps them aligned with the handshake.
  sequence s_wr_answered;
    state_r == ST_WAIT && ack_s2_r;
  endsequence

  sequence s_last_ok;
    s_wr_answered ##0 (!fail_s2_r && left_r == 7'h01);
  endsequence

  a_busy_active_pair: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    busy_r == active_r) else $error("busy and active differ");

  a_start_busy: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (start_rise && pos_ok && req_in.count >= COUNT_MIN && req_in.count <= COUNT_MAX
     && 7'(req_in.source_ref) + req_in.count <= 7'(DEPTH)) |=> busy_r && active_r)
    else $error("start edge did not raise busy");

  a_done_not_busy: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    $rose(done_r) |-> !busy_r && $past(busy_r)) else $error("done rose without busy drop");

  a_done_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    done_r && start_r |=> done_r) else $error("done dropped while start high");

  a_done_clear: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    done_r && !start_r |=> !done_r) else $error("done not cleared");

  a_err_code: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    error_r == (fault_code_r != FAULT_NONE)) else $error("error and fault code disagree");

  a_bad_pos: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    start_rise && !pos_ok |=> error_r && fault_code_r == FAULT_POSITION && !busy_r)
    else $error("bad position not flagged");

  a_err_clear: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    error_r && !start_r |=> !error_r && fault_code_r == FAULT_NONE)
    else $error("error not cleared");

  a_req_stable: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    busy_r && $past(busy_r) |-> $stable(req_r)) else $error("latched request changed");

  a_no_restart: assert property (@(posedge ref_clk) disable iff (rst) // RULE17
    busy_r |-> !start_rise) else $error("restart while busy");

  a_issue_ack_low: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    $rose(mod_wr_valid) |-> !$past(ack_s2_r)) else $error("write issued on stale answer");

  a_valid_drop: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    s_wr_answered |=> !mod_wr_valid) else $error("write request held after answer");

  a_fail_fault: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    s_wr_answered ##0 fail_s2_r |=> error_r && fault_code_r == FAULT_WRITE && !busy_r)
    else $error("failed write not flagged");

  a_done_count: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    s_last_ok |=> done_r && !busy_r && acked_r == req_r.count)
    else $error("done without every write answered");

  a_err_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    error_r && start_r |=> error_r && $stable(fault_code_r))
    else $error("error dropped while start high");

endmodule // emw_writer

// ### emw_pkg.sv
// Package of constants and types for the extension module register writer.
package emw_pkg;

  // Position encoding of extension modules.
  localparam logic [7:0]  RIGHT_POS_FIRST   = 8'h00;
  localparam logic [7:0]  RIGHT_POS_LAST    = 8'h07;
  localparam logic [7:0]  LEFT_POS_BASE     = 8'h64;
  localparam logic [7:0]  LEFT_POS_LAST     = 8'h6B;
  localparam int          MODULES_PER_SIDE  = 8;

  // Register count limits.
  localparam logic [6:0]  COUNT_MIN         = 7'h01;
  localparam logic [6:0]  COUNT_MAX         = 7'h40;

  // Fault codes.
  localparam logic [15:0] FAULT_NONE        = 16'h0000;
  localparam logic [15:0] FAULT_POSITION    = 16'h0001;
  localparam logic [15:0] FAULT_COUNT       = 16'h0002;
  localparam logic [15:0] FAULT_WRITE       = 16'h0003;
  localparam logic [15:0] FAULT_SOURCE      = 16'h0004;

  // APB register byte addresses.
  localparam logic [11:0] REG_CTRL          = 12'h000;
  localparam logic [11:0] REG_POSITION      = 12'h004;
  localparam logic [11:0] REG_FIRST_TARGET  = 12'h008;
  localparam logic [11:0] REG_COUNT         = 12'h00C;
  localparam logic [11:0] REG_SOURCE_REF    = 12'h010;
  localparam logic [11:0] REG_STATUS        = 12'h014;
  localparam logic [11:0] REG_FAULT         = 12'h018;
  localparam logic [11:0] REG_IRQ_STATUS    = 12'h01C;
  localparam logic [11:0] REG_IRQ_ENABLE    = 12'h020;
  localparam logic [11:0] REG_IRQ_CLEAR     = 12'h024;
  localparam logic [11:0] REG_DATA_BASE     = 12'h100;

  // Reset value and interrupt bit positions.
  localparam logic [31:0] RST_WORD          = 32'h0000_0000;
  localparam logic [1:0]  IRQ_DONE_BIT      = 2'h0;
  localparam logic [1:0]  IRQ_ERR_BIT       = 2'h1;

  // Parameters latched on the start edge.
  typedef struct packed {
    logic [7:0]  position;
    logic [15:0] first_target;
    logic [6:0]  count;
    logic [5:0]  source_ref;
  } emw_req_t;

  // One write to an extension module.
  typedef struct packed {
    logic        left_side;
    logic [2:0]  slot;
    logic [15:0] target;
    logic [15:0] data;
  } emw_wr_t;

endpackage

// ### emw_apb_regs.sv
// APB slave holding the request parameters, source array and interrupt registers.
`timescale 1ns/1ps
module emw_apb_regs
  import emw_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Block side
  output logic             start_r,
  output emw_req_t         req_r,
  input  wire logic [5:0]  src_idx,
  output logic      [15:0] src_data,
  input  wire logic [3:0]  status,
  input  wire logic [15:0] fault,
  input  wire logic        ev_done,
  input  wire logic        ev_err,
  output logic             irq
);

  logic [15:0] mem_r [DEPTH];
  logic [1:0]  irq_st_r;
  logic [1:0]  irq_en_r;
  logic        wr_en;
  logic        rd_en;
  logic        is_data;
  logic [1:0]  clr;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign is_data = paddr >= REG_DATA_BASE && paddr < REG_DATA_BASE + 12'(DEPTH * 4);
  assign src_data = mem_r[src_idx];
  assign clr = (wr_en && paddr == REG_IRQ_CLEAR) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_r  <= 1'b0;
      req_r    <= '0;
      irq_en_r <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        REG_CTRL:         start_r <= pwdata[0];
        REG_POSITION:     req_r.position <= pwdata[7:0];
        REG_FIRST_TARGET: req_r.first_target <= pwdata[15:0];
        REG_COUNT:        req_r.count <= pwdata[6:0];
        REG_SOURCE_REF:   req_r.source_ref <= pwdata[5:0];
        REG_IRQ_ENABLE:   irq_en_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en && is_data) begin
      mem_r[paddr[7:2]] <= pwdata[15:0];
    end
  end

  // Set wins over a simultaneous clear so that no event is lost.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_st_r <= 2'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~clr) | {ev_err, ev_done};
      irq      <= |(((irq_st_r & ~clr) | {ev_err, ev_done}) & irq_en_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata  <= RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= RST_WORD;
        if (pwrite ? (paddr == REG_STATUS || paddr == REG_FAULT || paddr == REG_IRQ_STATUS)
                   : paddr == REG_IRQ_CLEAR) begin
          pslverr <= 1'b1;
        end
        if (!pwrite) begin
          case (paddr)
            REG_CTRL:         prdata <= {31'h0, start_r};
            REG_POSITION:     prdata <= {24'h0, req_r.position};
            REG_FIRST_TARGET: prdata <= {16'h0, req_r.first_target};
            REG_COUNT:        prdata <= {25'h0, req_r.count};
            REG_SOURCE_REF:   prdata <= {26'h0, req_r.source_ref};
            REG_STATUS:       prdata <= {28'h0, status};
            REG_FAULT:        prdata <= {16'h0, fault};
            REG_IRQ_STATUS:   prdata <= {30'h0, irq_st_r};
            REG_IRQ_ENABLE:   prdata <= {30'h0, irq_en_r};
            default: begin
              if (is_data) begin
                prdata <= {16'h0, mem_r[paddr[7:2]]};
              end else begin
                pslverr <= 1'b1;
              end
            end
          endcase
        end else if (!is_data && paddr > REG_IRQ_CLEAR) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // rd_en is kept for symmetry with wr_en; the read answer is prepared in setup.
  logic unused_rd;
  assign unused_rd = rd_en;

endmodule // emw_apb_regs

// ### emw_pos_decode.sv
// Decoder of a module position into side and slot.
`timescale 1ns/1ps
module emw_pos_decode
  import emw_pkg::*;
(
  // Position in
  input  wire logic [7:0] position,
  // Decoded
  output logic            valid,
  output logic            left_side,
  output logic [2:0]      slot
);

  always_comb begin
    valid     = 1'b0;
    left_side = 1'b0;
    slot      = 3'h0;
    if (position <= RIGHT_POS_LAST) begin // RULE8
      valid = 1'b1;
      slot  = position[2:0];
    end else if (position >= LEFT_POS_BASE && position <= LEFT_POS_LAST) begin // RULE9
      valid     = 1'b1;
      left_side = 1'b1;
      slot      = 3'(position - LEFT_POS_BASE);
    end
  end

endmodule // emw_pos_decode

// ### emw_ext_model.sv
// Behavioural extension module that takes and acknowledges register writes.
`timescale 1ns/1ps
module emw_ext_model
  import emw_pkg::*;
(
  // Clock
  input  wire logic    ref_clk,
  // Write port
  input  wire logic    mod_wr_valid,
  input  wire emw_wr_t mod_wr,
  output logic         mod_wr_ack,
  output logic         mod_wr_fail
);
  int      slow    = 0;
  logic    fail_en = 1'b0;
  int      n_wr    = 0;
  int      cnt     = 0;
  emw_wr_t log_wr [256];

  initial begin
    mod_wr_ack  = 1'b0;
    mod_wr_fail = 1'b0;
  end

  // Fail only means something beside ack, so it toggles while mod_wr_valid is low and nothing leans on a stale level.
  always @(posedge ref_clk) begin
    if (!mod_wr_valid) begin
      mod_wr_ack  <= 1'b0;
      mod_wr_fail <= ~mod_wr_fail;
      cnt         <= 0;
    end else if (!mod_wr_ack) begin
      if (cnt >= slow) begin
        mod_wr_ack         <= 1'b1;
        mod_wr_fail        <= fail_en;
        log_wr[n_wr % 256] <= mod_wr;
        n_wr               <= n_wr + 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // emw_ext_model

// ### test_extension_module_register_writer.sv
// Self-checking bench for the extension module register writer.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module test_extension_module_register_writer;
  import emw_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        mod_wr_valid, mod_wr_ack, mod_wr_fail;
  emw_wr_t     mod_wr;
  logic        done_r, busy_r, active_r, error_r, irq;
  logic [15:0] fault_code_r;
  int          n_mismatch = 0;
  int          checked = 0;

  emw_writer uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_wr_valid(mod_wr_valid), .mod_wr(mod_wr),
    .mod_wr_ack(mod_wr_ack), .mod_wr_fail(mod_wr_fail), .done_r(done_r), .busy_r(busy_r),
    .active_r(active_r), .error_r(error_r), .fault_code_r(fault_code_r), .irq(irq));
  emw_ext_model ext (.ref_clk(ref_clk), .mod_wr_valid(mod_wr_valid), .mod_wr(mod_wr),
    .mod_wr_ack(mod_wr_ack), .mod_wr_fail(mod_wr_fail));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    n_mismatch++;
    $display("Error timeout expected 1 seen 0");
    tally_and_finish();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timed_out();
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic run(input logic [7:0] pos, input logic [15:0] tgt,
                     input logic [6:0] cnt, input logic [5:0] src);
    wr(REG_POSITION, {24'h0, pos});
    wr(REG_FIRST_TARGET, {16'h0, tgt});
    wr(REG_COUNT, {25'h0, cnt});
    wr(REG_SOURCE_REF, {26'h0, src});
    wr(REG_CTRL, 32'h0000_0001);
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (done_r !== 1'b1 && error_r !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) timed_out();
  endtask

  task automatic finish_op();
    wr(REG_CTRL, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    `CHK("done", 1'b0, done_r)
    `CHK("error", 1'b0, error_r)
    `CHK("fault", FAULT_NONE, fault_code_r)
  endtask

  task automatic t_multi();
    int          n0;
    int          n;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 4; i++) wr(REG_DATA_BASE + 12'(4 * (5 + i)), 32'h0000_A000 + i);
    wr(REG_IRQ_ENABLE, 32'h0000_0001);
    ext.slow = 2;
    n0 = ext.n_wr;
    run(8'h03, 16'h0010, 7'h04, 6'h05);
    n = 0;
    while (busy_r !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (busy_r !== 1'b1) timed_out();
    `CHK("active", 1'b1, active_r)
    wr(REG_POSITION, 32'h0000_006B);
    wait_end();
    `CHK("done", 1'b1, done_r)
    `CHK("busy", 1'b0, busy_r)
    `CHK("active", 1'b0, active_r)
    `CHK("count", 4, ext.n_wr - n0)
    for (int i = 0; i < 4; i++) begin
      `CHK("target", 16'h0010 + 16'(i), ext.log_wr[n0 + i].target)
      `CHK("data", 16'hA000 + 16'(i), ext.log_wr[n0 + i].data)
      `CHK("slot", 3'h3, ext.log_wr[n0 + i].slot)
      `CHK("left", 1'b0, ext.log_wr[n0 + i].left_side)
    end
    `CHK("irq", 1'b1, irq)
    repeat (5) @(posedge ref_clk);
    `CHK("done", 1'b1, done_r)
    apb(1'b0, REG_IRQ_STATUS, 32'h0, q, e);
    `CHK("irq status", 1'b1, q[0])
    wr(REG_IRQ_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    `CHK("irq", 1'b0, irq)
    finish_op();
    ext.slow = 0;
    $display("t_multi finished");
  endtask

  task automatic t_left();
    logic [7:0] p [2] = '{8'h64, 8'h6B};
    for (int k = 0; k < 2; k++) begin
      wr(REG_DATA_BASE, 32'h0000_0055);
      run(p[k], 16'h0002, 7'h01, 6'h00);
      wait_end();
      `CHK("slot", p[k][2:0] - 3'h4, ext.log_wr[(ext.n_wr - 1) % 256].slot)
      `CHK("left", 1'b1, ext.log_wr[(ext.n_wr - 1) % 256].left_side)
      finish_op();
    end
    $display("t_left finished");
  endtask

  task automatic t_bad();
    logic [7:0]  p [7] = '{8'h08, 8'h63, 8'h6C, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [6:0]  c [7] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h00, 7'h41, 7'h04};
    logic [5:0]  s [7] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h3E};
    logic [15:0] f [7] = '{FAULT_POSITION, FAULT_POSITION, FAULT_POSITION,
                           FAULT_POSITION, FAULT_COUNT, FAULT_COUNT, FAULT_SOURCE};
    int          n0;
    for (int k = 0; k < 7; k++) begin
      n0 = ext.n_wr;
      run(p[k], 16'h0000, c[k], s[k]);
      wait_end();
      `CHK("error", 1'b1, error_r)
      `CHK("fault", f[k], fault_code_r)
      `CHK("busy", 1'b0, busy_r)
      `CHK("writes", 0, ext.n_wr - n0)
      finish_op();
    end
    $display("t_bad finished");
  endtask

  task automatic t_fail();
    ext.fail_en = 1'b1;
    run(8'h00, 16'h0004, 7'h02, 6'h00);
    wait_end();
    `CHK("error", 1'b1, error_r)
    `CHK("fault", FAULT_WRITE, fault_code_r)
    `CHK("done", 1'b0, done_r)
    ext.fail_en = 1'b0;
    finish_op();
    $display("t_fail finished");
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    `CHK("status", 32'h0, q)
    apb(1'b0, 12'h0FC, 32'h0, q, e);
    `CHK("unmapped", 1'b1, e)
    apb(1'b1, REG_FAULT, 32'h0000_FFFF, q, e);
    `CHK("read only", 1'b1, e)
    $display("t_regs finished");
  endtask

  initial begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_multi();
    t_left();
    t_bad();
    t_fail();
    tally_and_finish();
  end
endmodule // test_extension_module_register_writer
